/* File: core/asd_pkg.sv */
// package for the add and shift execution datapath
// assumes one core clock; decoder supplies binary-encoded 3-bit op codes
package asd_pkg;
	// operation select from the decoder
	typedef enum logic [2:0] {
		ASD_OP_NONE,
		ASD_OP_POINTER_LITERAL_ADD,
		ASD_OP_LITERAL_AND,
		ASD_OP_LITERAL_ADD,
		ASD_OP_REGISTER_AND,
		ASD_OP_REGISTER_ADD,
		ASD_OP_ARITH_SHIFT_RIGHT,
		ASD_OP_REGISTER_ADD_CARRY
	} asd_op_t;
	localparam int ASD_DATA_W = 8;
	localparam int ASD_PTR_W = 16;
	localparam int ASD_OFS_W = 6;
	localparam int ASD_FADDR_W = 7;
	localparam int ASD_NIB_BIT = 4;
	localparam int ASD_MSB = 7;
	localparam logic ASD_DEST_ACC = 1'b0;
	localparam logic [7:0] ASD_ACC_RST = 8'h00;
	localparam logic [15:0] ASD_PTR_RST = 16'h0000;
endpackage

/* File: core/asd_datapath.sv */
// execution datapath for add, and and shift operations of an 8-bit core
// assumes decoder presents op and operands for one cycle with op_valid_in
// Summary of operation
// - pointer add sign-extends 6-bit literal onto chosen 16-bit pointer, flags unchanged
// - pointer sum wraps modulo 2^16, never saturates
// - literal and: accumulator AND 8-bit literal into accumulator, only zero flag
// - literal add: accumulator plus literal into accumulator, carry, nibble carry, zero
// - register and: accumulator AND file register, zero only, dest bit selects target
// - register add: accumulator plus file register, three flags, dest bit selects target
// - arithmetic shift right keeps bit 7, bit 0 to carry, updates carry and zero
// - add with carry: accumulator plus file register plus carry, three flags, dest select
`default_nettype none
module asd_datapath
	import asd_pkg::*;
(
	input wire logic clk_in, // core clock
	input wire logic rstn_in, // sync reset, low
	input wire logic op_valid_in, // operation present
	input wire asd_pkg::asd_op_t op_in, // operation select
	input wire logic [asd_pkg::ASD_DATA_W-1:0] literal_in, // 8-bit literal
	input wire logic [asd_pkg::ASD_OFS_W-1:0] ptr_ofs_in, // signed pointer offset
	input wire logic ptr_sel_in, // pointer 0 or 1
	input wire logic [asd_pkg::ASD_FADDR_W-1:0] faddr_in, // file register address
	input wire logic [asd_pkg::ASD_DATA_W-1:0] fdata_in, // file register contents
	input wire logic dest_in, // 0 accumulator, 1 file
	output logic [asd_pkg::ASD_DATA_W-1:0] acc_out, // accumulator
	output logic carry_flag_out, // carry flag
	output logic nibble_carry_flag_out, // nibble carry flag
	output logic zero_flag_out, // zero flag
	output logic [asd_pkg::ASD_PTR_W-1:0] ptr0_out, // indirect pointer 0
	output logic [asd_pkg::ASD_PTR_W-1:0] ptr1_out, // indirect pointer 1
	output logic fwrite_out, // file write pulse
	output logic [asd_pkg::ASD_FADDR_W-1:0] fwaddr_out, // file write address
	output logic [asd_pkg::ASD_DATA_W-1:0] fwdata_out // file write data
);
	import asd_pkg::*;

	logic [ASD_DATA_W-1:0] acc_q;
	logic c_q, nc_q, z_q;
	logic [ASD_PTR_W-1:0] ptr_q [2];
	logic fwr_q;
	logic [ASD_FADDR_W-1:0] fwa_q;
	logic [ASD_DATA_W-1:0] fwd_q;
	logic [ASD_DATA_W-1:0] res_d, add_b;
	logic cin, c_d, nc_d, is_add, is_and, is_shift, is_reg, to_acc;
	logic [ASD_NIB_BIT:0] lo_sum;
	logic [ASD_DATA_W:0] full_sum;
	logic [ASD_PTR_W-1:0] ptr_sum;

	// operand and result selection
	always_comb begin
		is_add = (op_in == ASD_OP_LITERAL_ADD) || (op_in == ASD_OP_REGISTER_ADD)
			|| (op_in == ASD_OP_REGISTER_ADD_CARRY);
		is_and = (op_in == ASD_OP_LITERAL_AND) || (op_in == ASD_OP_REGISTER_AND);
		is_shift = (op_in == ASD_OP_ARITH_SHIFT_RIGHT);
		is_reg = (op_in == ASD_OP_REGISTER_AND) || (op_in == ASD_OP_REGISTER_ADD)
			|| (op_in == ASD_OP_ARITH_SHIFT_RIGHT) || (op_in == ASD_OP_REGISTER_ADD_CARRY);
		add_b = is_reg ? fdata_in : literal_in;
		cin = (op_in == ASD_OP_REGISTER_ADD_CARRY) ? c_q : 1'b0;
		lo_sum = {1'b0, acc_q[ASD_NIB_BIT-1:0]} + {1'b0, add_b[ASD_NIB_BIT-1:0]}
			+ {{ASD_NIB_BIT{1'b0}}, cin};
		full_sum = {1'b0, acc_q} + {1'b0, add_b} + {{ASD_DATA_W{1'b0}}, cin};
		c_d = c_q;
		nc_d = nc_q;
		case (op_in)
			ASD_OP_LITERAL_AND, ASD_OP_REGISTER_AND: begin
				res_d = acc_q & add_b;
			end
			ASD_OP_LITERAL_ADD, ASD_OP_REGISTER_ADD, ASD_OP_REGISTER_ADD_CARRY: begin
				res_d = full_sum[ASD_DATA_W-1:0];
				c_d = full_sum[ASD_DATA_W];
				nc_d = lo_sum[ASD_NIB_BIT];
			end
			ASD_OP_ARITH_SHIFT_RIGHT: begin
				res_d = {fdata_in[ASD_MSB], fdata_in[ASD_MSB:1]};
				c_d = fdata_in[0];
			end
			default: begin
				res_d = acc_q;
			end
		endcase
		// literal ops always target the accumulator
		to_acc = !is_reg || (dest_in == ASD_DEST_ACC);
		ptr_sum = ptr_q[ptr_sel_in] + {{(ASD_PTR_W-ASD_OFS_W){ptr_ofs_in[ASD_OFS_W-1]}}, ptr_ofs_in};
	end

	// accumulator update
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			acc_q <= ASD_ACC_RST;
		end else if (op_valid_in && (is_add || is_and || is_shift) && to_acc) begin
			acc_q <= res_d;
		end
	end

	// status flags; untouched flags hold
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			c_q <= 1'b0;
			nc_q <= 1'b0;
			z_q <= 1'b0;
		end else if (op_valid_in && (is_add || is_and || is_shift)) begin
			c_q <= c_d;
			nc_q <= nc_d;
			z_q <= (res_d == '0);
		end
	end

	// indirect pointers, wrapping add
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			ptr_q[0] <= ASD_PTR_RST;
			ptr_q[1] <= ASD_PTR_RST;
		end else if (op_valid_in && op_in == ASD_OP_POINTER_LITERAL_ADD) begin
			ptr_q[ptr_sel_in] <= ptr_sum;
		end
	end

	// file register write-back
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			fwr_q <= 1'b0;
			fwa_q <= '0;
			fwd_q <= '0;
		end else begin
			fwr_q <= op_valid_in && is_reg && !to_acc;
			fwa_q <= faddr_in;
			fwd_q <= res_d;
		end
	end

	assign acc_out = acc_q;
	assign carry_flag_out = c_q;
	assign nibble_carry_flag_out = nc_q;
	assign zero_flag_out = z_q;
	assign ptr0_out = ptr_q[0];
	assign ptr1_out = ptr_q[1];
	assign fwrite_out = fwr_q;
	assign fwaddr_out = fwa_q;
	assign fwdata_out = fwd_q;

	// pointer add leaves flags alone
	property p_ptr_flags;
		@(posedge clk_in) disable iff (!rstn_in)
		(op_valid_in && op_in == ASD_OP_POINTER_LITERAL_ADD)
			|=> $stable(c_q) && $stable(nc_q) && $stable(z_q);
	endproperty
	a_ptr_flags: assert property (p_ptr_flags) else $error("pointer add changed a flag");

	// pointer 0 wraps modulo 2^16
	property p_ptr_wrap;
		@(posedge clk_in) disable iff (!rstn_in)
		(op_valid_in && op_in == ASD_OP_POINTER_LITERAL_ADD && !ptr_sel_in)
			|=> ptr_q[0] == 16'($past(ptr_q[0]) + {{10{$past(ptr_ofs_in[5])}}, $past(ptr_ofs_in)});
	endproperty
	a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer sum wrong");

	// literal and result and carry hold
	property p_land;
		@(posedge clk_in) disable iff (!rstn_in)
		(op_valid_in && op_in == ASD_OP_LITERAL_AND)
			|=> acc_q == ($past(acc_q) & $past(literal_in)) && $stable(c_q) && $stable(nc_q);
	endproperty
	a_land: assert property (p_land) else $error("literal and wrong");

	// literal add result and carry
	property p_ladd;
		@(posedge clk_in) disable iff (!rstn_in)
		(op_valid_in && op_in == ASD_OP_LITERAL_ADD)
			|=> {c_q, acc_q} == {1'b0, $past(acc_q)} + {1'b0, $past(literal_in)};
	endproperty
	a_ladd: assert property (p_ladd) else $error("literal add wrong");

	// register and to file keeps accumulator
	property p_rand_f;
		@(posedge clk_in) disable iff (!rstn_in)
		(op_valid_in && op_in == ASD_OP_REGISTER_AND && dest_in)
			|=> fwr_q && $stable(acc_q) && fwd_q == ($past(acc_q) & $past(fdata_in));
	endproperty
	a_rand_f: assert property (p_rand_f) else $error("register and dest wrong");

	// register add to accumulator, no file write
	property p_radd;
		@(posedge clk_in) disable iff (!rstn_in)
		(op_valid_in && op_in == ASD_OP_REGISTER_ADD && !dest_in)
			|=> !fwr_q && {c_q, acc_q} == {1'b0, $past(acc_q)} + {1'b0, $past(fdata_in)};
	endproperty
	a_radd: assert property (p_radd) else $error("register add wrong");

	// shift keeps msb, lsb to carry
	property p_asr;
		@(posedge clk_in) disable iff (!rstn_in)
		(op_valid_in && op_in == ASD_OP_ARITH_SHIFT_RIGHT && dest_in)
			|=> c_q == $past(fdata_in[0]) && fwd_q[7] == $past(fdata_in[7]) && $stable(nc_q);
	endproperty
	a_asr: assert property (p_asr) else $error("shift wrong");

	// add with carry includes old carry
	property p_addc;
		@(posedge clk_in) disable iff (!rstn_in)
		(op_valid_in && op_in == ASD_OP_REGISTER_ADD_CARRY && !dest_in)
			|=> {c_q, acc_q} == {1'b0, $past(acc_q)} + {1'b0, $past(fdata_in)} + {8'h00, $past(c_q)};
	endproperty
	a_addc: assert property (p_addc) else $error("add with carry wrong");

	// zero flag tracks result
	property p_zero;
		@(posedge clk_in) disable iff (!rstn_in)
		(op_valid_in && !dest_in && (op_in == ASD_OP_LITERAL_ADD || op_in == ASD_OP_REGISTER_ADD))
			|=> z_q == (acc_q == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");

	// idle cycles keep all flags
	property p_hold;
		@(posedge clk_in) disable iff (!rstn_in)
		(!op_valid_in) |=> $stable(c_q) && $stable(nc_q) && $stable(z_q) && $stable(acc_q);
	endproperty
	a_hold: assert property (p_hold) else $error("state changed while idle");
endmodule
`default_nettype wire

/* File: sim/tb_add_and_shift_datapath.sv */
// self-checking bench for the add and shift execution datapath
// assumes asd_pkg and asd_datapath compiled first; bench drives all ports
`default_nettype none
module tb_add_and_shift_datapath import asd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {time t; logic [7:0] a; logic c, nc, z; logic [15:0] p0, p1;
		logic fw; logic [6:0] fa; logic [7:0] fd;} asd_exp_t;
	logic clk_in = 1'b0, rstn_in = 1'b0, valid = 1'b0, sel = 1'b0, dest = 1'b0;
	asd_op_t op = ASD_OP_NONE;
	logic [7:0] lit = 8'h00, fdat = 8'h00;
	logic [5:0] ofs = 6'h00;
	logic [6:0] fad = 7'h00;
	logic [7:0] acc, fwd;
	logic c, nc, z, fw;
	logic [15:0] p0, p1;
	logic [6:0] fwa;
	asd_exp_t q[$];
	asd_exp_t m, e;
	int n_fail = 0, comparisons = 0, cyc = 0;

	asd_datapath DUT (.clk_in(clk_in), .rstn_in(rstn_in), .op_valid_in(valid), .op_in(op),
		.literal_in(lit), .ptr_ofs_in(ofs), .ptr_sel_in(sel), .faddr_in(fad), .fdata_in(fdat),
		.dest_in(dest), .acc_out(acc), .carry_flag_out(c), .nibble_carry_flag_out(nc),
		.zero_flag_out(z), .ptr0_out(p0), .ptr1_out(p1), .fwrite_out(fw), .fwaddr_out(fwa),
		.fwdata_out(fwd));

	// 50 mhz clock
	initial begin
		forever #10 clk_in = ~clk_in;
	end

	task automatic close_out;
		if (n_fail == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [15:0] g, input logic [15:0] x);
		comparisons++;
		if (g !== x) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, g, x);
		end
	endtask

	// drive one cycle and note what the datapath must show after it
	task automatic issue(input asd_op_t o, input logic v, input logic [7:0] l, f,
		input logic [5:0] k, input logic s, d, input logic [6:0] a);
		logic [8:0] sum;
		logic [4:0] nib;
		logic [7:0] b, r;
		logic cin;
		@(posedge clk_in);
		valid <= v; op <= o; lit <= l; fdat <= f; ofs <= k; sel <= s; dest <= d; fad <= a;
		m.fw = 1'b0;
		m.t = $time;
		b = (o == ASD_OP_LITERAL_ADD || o == ASD_OP_LITERAL_AND) ? l : f;
		cin = (o == ASD_OP_REGISTER_ADD_CARRY) ? m.c : 1'b0;
		sum = {1'b0, m.a} + {1'b0, b} + {8'h00, cin};
		nib = {1'b0, m.a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		if (o == ASD_OP_LITERAL_AND || o == ASD_OP_REGISTER_AND)
			r = m.a & b;
		else if (o == ASD_OP_ARITH_SHIFT_RIGHT)
			r = {f[7], f[7:1]};
		else
			r = sum[7:0];
		if (v && o == ASD_OP_POINTER_LITERAL_ADD) begin
			if (s) m.p1 = m.p1 + {{10{k[5]}}, k};
			else m.p0 = m.p0 + {{10{k[5]}}, k};
		end else if (v && o != ASD_OP_NONE) begin
			m.z = (r == 8'h00);
			if (o == ASD_OP_ARITH_SHIFT_RIGHT) m.c = f[0];
			else if (o != ASD_OP_LITERAL_AND && o != ASD_OP_REGISTER_AND) begin
				m.c = sum[8];
				m.nc = nib[4];
			end
			if (d && o != ASD_OP_LITERAL_AND && o != ASD_OP_LITERAL_ADD) begin
				m.fw = 1'b1; m.fa = a; m.fd = r;
			end else m.a = r;
		end
		q.push_back(m);
	endtask

	// results land one edge after the op is taken
	always @(negedge clk_in) begin
		if (q.size() > 0 && q[0].t + 20 <= $time) begin
			e = q.pop_front();
			chk(16'(acc), 16'(e.a));
			chk(16'(c), 16'(e.c));
			chk(16'(nc), 16'(e.nc));
			chk(16'(z), 16'(e.z));
			chk(p0, e.p0);
			chk(p1, e.p1);
			chk(16'(fw), 16'(e.fw));
			if (e.fw) begin
				chk(16'(fwa), 16'(e.fa));
				chk(16'(fwd), 16'(e.fd));
			end
		end
	end

	// hang guard
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			close_out();
		end
	end

	// directed corner cases, then random back-to-back traffic
	initial begin
		m = '{default: '0};
		void'($urandom(32'h92a05a53));
		repeat (12) @(posedge clk_in);
		rstn_in <= 1'b1;
		issue(ASD_OP_NONE, 1'b1, 8'h00, 8'h00, 6'h00, 1'b0, 1'b0, 7'h00);
		issue(ASD_OP_LITERAL_ADD, 1'b1, 8'hff, 8'h00, 6'h00, 1'b0, 1'b1, 7'h00);
		issue(ASD_OP_LITERAL_ADD, 1'b1, 8'h01, 8'h00, 6'h00, 1'b0, 1'b0, 7'h00);
		issue(ASD_OP_REGISTER_ADD_CARRY, 1'b1, 8'h00, 8'h0f, 6'h00, 1'b0, 1'b0, 7'h05);
		issue(ASD_OP_REGISTER_AND, 1'b1, 8'h00, 8'hf0, 6'h00, 1'b0, 1'b1, 7'h7f);
		issue(ASD_OP_ARITH_SHIFT_RIGHT, 1'b1, 8'h00, 8'h81, 6'h00, 1'b0, 1'b0, 7'h00);
		issue(ASD_OP_LITERAL_AND, 1'b1, 8'h0f, 8'h00, 6'h00, 1'b0, 1'b1, 7'h00);
		issue(ASD_OP_POINTER_LITERAL_ADD, 1'b1, 8'h00, 8'h00, 6'h3f, 1'b0, 1'b0, 7'h00);
		issue(ASD_OP_POINTER_LITERAL_ADD, 1'b1, 8'h00, 8'h00, 6'h1f, 1'b0, 1'b0, 7'h00);
		issue(ASD_OP_POINTER_LITERAL_ADD, 1'b1, 8'h00, 8'h00, 6'h20, 1'b1, 1'b0, 7'h00);
		issue(ASD_OP_REGISTER_ADD, 1'b0, 8'h00, 8'h55, 6'h00, 1'b0, 1'b0, 7'h00);
		repeat (600) issue(asd_op_t'($urandom_range(7, 0)), 1'($urandom_range(3, 0) != 0), 8'($urandom),
			8'($urandom), 6'($urandom), 1'($urandom), 1'($urandom), 7'($urandom));
		repeat (3) issue(ASD_OP_NONE, 1'b0, 8'h00, 8'h00, 6'h00, 1'b0, 1'b0, 7'h00);
		// let the last notes be compared before the verdict
		wait (q.size() == 0);
		close_out();
	end
endmodule
`default_nettype wire
